// ---- src/pll_fabric_interface.sv ----
`timescale 1ns/1ps
// Functional notes
// - Four references, two-bit selector picks one
// - Active-low reset holds PLL in reset
// - Output zero at most four times reference
// - Lock rises on lock, drops on loss
// - Lock is asynchronous; user must synchronise it
// - Each step code adds half-cycle delay
// - Five-bit select picks affected outputs
// - Apply strobe high loads new phase
module pll_fabric_interface (
    input  wire logic                                   clock,                  // 250 MHz
    input  wire logic                                   srst,                   // Sync reset
    input  wire logic [pll_fabric_pkg::REF_COUNT-1:0]   reference_clock_inputs, // Refs
    input  wire logic [pll_fabric_pkg::SEL_W-1:0]       reference_select,       // Ref select
    input  wire logic                                   pll_reset_n,            // PLL reset
    input  wire logic                                   feedback_from_pad,      // Pad fb mode
    input  wire logic                                   core_feedback_in,       // Core fb
    input  wire logic                                   pad_feedback_in,        // Pad fb
    input  wire logic [pll_fabric_pkg::STEP_W-1:0]      phase_step_code,        // Step code
    input  wire logic [pll_fabric_pkg::NUM_OUTPUTS-1:0] phase_output_select,    // Out select
    input  wire logic                                   phase_apply_strobe,     // Apply
    output logic                                        pll_output_zero,        // Clock 0
    output logic                                        pll_output_one,         // Clock 1
    output logic                                        pll_output_two,         // Clock 2
    output logic                                        pll_output_three,       // Clock 3
    output logic                                        pll_output_four,        // Clock 4
    output logic                                        lock_indicator,         // Lock
    output logic                                        output_zero_in_range    // Clk0 ok
);
    import pll_fabric_pkg::*;

    typedef struct packed {
        pll_state_e       state;
        logic             running;
        logic             ref_q;
        logic             fb_q;
        logic [CNT_W-1:0] ref_cnt;
        logic [CNT_W-1:0] fb_cnt;
        logic [CNT_W-1:0] ref_per;
        logic [CNT_W-1:0] fb_per;
        logic [2:0]       match;
        logic             lock;
        logic             out0_ok;
    } pll_state_s;

    pll_state_s s;
    pll_state_s next_s;
    logic             ref_bit;
    logic             fb_bit;
    logic             ref_rise;
    logic             fb_rise;
    logic [CNT_W-1:0] fb_per_now;
    logic             period_equal;
    logic [NUM_OUTPUTS-1:0] out_vec;

    always_comb begin
        ref_bit      = reference_clock_inputs[reference_select];
        fb_bit       = feedback_from_pad ? pad_feedback_in : core_feedback_in;
        ref_rise     = ref_bit && !s.ref_q;
        fb_rise      = fb_bit && !s.fb_q;
        fb_per_now   = fb_rise ? s.fb_cnt : s.fb_per;
        period_equal = (fb_per_now == s.ref_cnt) && (s.ref_cnt != CNT_MAX);
        next_s         = s;
        next_s.running = 1'b1;
        next_s.ref_q   = ref_bit;
        next_s.fb_q    = fb_bit;
        next_s.ref_cnt = (s.ref_cnt == CNT_MAX) ? s.ref_cnt : s.ref_cnt + 8'h1;
        next_s.fb_cnt  = (s.fb_cnt == CNT_MAX) ? s.fb_cnt : s.fb_cnt + 8'h1;
        // Output zero period times four must cover the reference period
        next_s.out0_ok = ({3'h0, OUT_PERIODS[0]} * OUT_ZERO_RATIO) >= {2'h0, s.ref_per};
        if (fb_rise) begin
            next_s.fb_per = s.fb_cnt;
            next_s.fb_cnt = 8'h1;
        end
        case (s.state)
            st_reset: begin
                next_s.state = st_acquire;
            end
            st_acquire: begin
                if (ref_rise) begin
                    if (!period_equal) begin
                        next_s.match = 3'h0;
                    end else if (s.match == LOCK_MATCH_LAST) begin
                        next_s.lock  = 1'b1;
                        next_s.state = st_lock_indicator;
                    end else begin
                        next_s.match = s.match + 3'h1;
                    end
                end
            end
            st_lock_indicator: begin
                if ((ref_rise && !period_equal) || s.ref_cnt == CNT_MAX ||
                    s.fb_cnt == CNT_MAX) begin
                    next_s.lock  = 1'b0;
                    next_s.match = 3'h0;
                    next_s.state = st_acquire;
                end
            end
            default: begin
                next_s.state = st_reset;
            end
        endcase
        if (ref_rise) begin
            next_s.ref_per = s.ref_cnt;
            next_s.ref_cnt = 8'h1;
        end
        if (!pll_reset_n) begin
            next_s       = '0;
            next_s.ref_q = ref_bit;
            next_s.fb_q  = fb_bit;
        end
        if (srst) begin
            next_s = '0;
        end
    end

    always_ff @(posedge clock) begin
        s <= next_s;
    end

    genvar i;
    generate
        for (i = 0; i < NUM_OUTPUTS; i = i + 1) begin : gen_out
            pll_output_divider #(
                .PERIOD (OUT_PERIODS[i])
            ) u_div (
                .clock     (clock),
                .srst      (srst),
                .run       (s.running),
                .enable    ((i == 0) ? s.out0_ok : 1'b1),
                .step_code (phase_step_code),
                .apply     (phase_apply_strobe && phase_output_select[i] && pll_reset_n),
                .clk_out   (out_vec[i])
            );
        end
    endgenerate

    assign pll_output_zero      = out_vec[0];
    assign pll_output_one       = out_vec[1];
    assign pll_output_two       = out_vec[2];
    assign pll_output_three     = out_vec[3];
    assign pll_output_four      = out_vec[4];
    // Straight from a flop, so glitch-free, but still unrelated to user clocks
    assign lock_indicator       = s.lock;
    assign output_zero_in_range = s.out0_ok;

    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    sequence lock_clear_s;
        !lock_indicator;
    endsequence
    sequence outputs_quiet_s;
        out_vec == '0;
    endsequence

    reset_quiet_a: assert property (!pll_reset_n |=> lock_clear_s ##1 outputs_quiet_s)
        else $error("PLL not held in reset");
    reset_lock_a: assert property (!pll_reset_n |=> !lock_indicator)
        else $error("lock high during PLL reset");
    lock_rise_a: assert property ($rose(lock_indicator) |-> $past(ref_rise) &&
        $past(period_equal) && $past(s.match) == LOCK_MATCH_LAST)
        else $error("lock raised without enough matches");
    lock_loss_a: assert property (lock_indicator && ref_rise && !period_equal &&
        pll_reset_n |=> !lock_indicator)
        else $error("lock kept after period mismatch");
    lock_cause_a: assert property ($changed(lock_indicator) |-> $past(!pll_reset_n) ||
        $past(ref_rise) || $past(s.ref_cnt) == CNT_MAX || $past(s.fb_cnt) == CNT_MAX)
        else $error("lock changed without cause");
    ref_edge_a: assert property (ref_rise && pll_reset_n |=> s.ref_cnt == 8'h1)
        else $error("selected reference edge not taken");
    out_zero_a: assert property (!s.out0_ok |=> !pll_output_zero)
        else $error("output zero runs out of range");

    // Run flag follows the PLL reset one edge late
    sequence pll_held_s;
        !pll_reset_n;
    endsequence
    sequence pll_released_s;
        pll_reset_n;
    endsequence

    run_stop_a: assert property (pll_held_s |=> !s.running && s.state == st_reset)
        else $error("PLL kept running in reset");
    run_start_a: assert property (pll_held_s ##1 pll_released_s |=> s.running)
        else $error("PLL did not start after reset release");
    ref_follow_a: assert property (pll_released_s |=>
        s.ref_q == $past(reference_clock_inputs[reference_select]))
        else $error("selected reference not sampled");

    // Lock flag and state machine move together
    lock_state_a: assert property (lock_indicator == (s.state == st_lock_indicator))
        else $error("lock and state disagree");
    lock_stall_a: assert property (lock_indicator && pll_reset_n &&
        (s.ref_cnt == CNT_MAX || s.fb_cnt == CNT_MAX) |=> !lock_indicator)
        else $error("lock kept with a missing clock edge");
    lock_hold_a: assert property (lock_indicator && pll_reset_n && !ref_rise &&
        s.ref_cnt != CNT_MAX && s.fb_cnt != CNT_MAX |=> lock_indicator)
        else $error("lock dropped without cause");
    early_lock_a: assert property (s.state == st_acquire &&
        s.match != LOCK_MATCH_LAST |=> !lock_indicator)
        else $error("lock raised before enough matches");

    // Range flag tracks the measured reference period
    range_cut_a: assert property (pll_reset_n &&
        {2'h0, s.ref_per} > {3'h0, OUT_PERIODS[0]} * OUT_ZERO_RATIO |=> !output_zero_in_range)
        else $error("output zero flagged in range too slow");
    range_ok_a: assert property (pll_reset_n &&
        {2'h0, s.ref_per} <= {3'h0, OUT_PERIODS[0]} * OUT_ZERO_RATIO |=> output_zero_in_range)
        else $error("output zero flagged out of range");
endmodule : pll_fabric_interface

// ---- src/pll_fabric_pkg.sv ----
package pll_fabric_pkg;
    localparam int REF_COUNT   = 4;
    localparam int SEL_W       = 2;
    localparam int STEP_W      = 3;
    localparam int NUM_OUTPUTS = 5;
    localparam int CNT_W       = 8;
    localparam int PER_W       = 7;

    // Period counters saturate here, which reads as a missing edge
    localparam logic [CNT_W-1:0] CNT_MAX = 8'hff;

    // Match count after which one more equal period declares lock, so four equal periods in a row
    localparam logic [2:0] LOCK_MATCH_LAST = 3'h3;

    // Timing in clock cycles at 250 MHz
    localparam int CLOCK_PERIOD_NS = 4;
    localparam int POST_DIV_NS     = 8;
    localparam int POST_DIV_CYCLES = POST_DIV_NS / CLOCK_PERIOD_NS;
    localparam logic [PER_W-1:0] HALF_STEP_CYCLES = PER_W'(POST_DIV_CYCLES / 2);

    // Output clock periods in clock cycles, output zero in the low slot
    localparam logic [NUM_OUTPUTS-1:0][PER_W-1:0] OUT_PERIODS =
        {7'h40, 7'h20, 7'h20, 7'h10, 7'h10};
    localparam logic [PER_W-1:0] OUT_PERIOD_DEFAULT = 7'h10;

    // Output zero may run at most this multiple of the reference
    localparam logic [CNT_W+1:0] OUT_ZERO_RATIO = 10'h004;

    typedef enum logic [1:0] {
        st_reset,
        st_acquire,
        st_lock_indicator
    } pll_state_e;
endpackage : pll_fabric_pkg

// ---- src/pll_output_divider.sv ----
`timescale 1ns/1ps
module pll_output_divider #(
    parameter logic [pll_fabric_pkg::PER_W-1:0] PERIOD = pll_fabric_pkg::OUT_PERIOD_DEFAULT
) (
    input  wire logic                              clock,     // System clock
    input  wire logic                              srst,      // Sync reset
    input  wire logic                              run,       // PLL out of reset
    input  wire logic                              enable,    // Output allowed
    input  wire logic [pll_fabric_pkg::STEP_W-1:0] step_code, // Phase step code
    input  wire logic                              apply,     // Apply to this output
    output logic                                   clk_out    // Divided clock
);
    import pll_fabric_pkg::*;

    typedef struct packed {
        logic [PER_W-1:0]  cnt;
        logic [STEP_W-1:0] shift;
        logic              out;
    } div_state_s;

    div_state_s s;
    div_state_s next_s;
    logic [PER_W-1:0] delay;
    logic [PER_W-1:0] pos;

    always_comb begin
        delay  = PER_W'(s.shift * HALF_STEP_CYCLES);
        pos    = (s.cnt >= delay) ? s.cnt - delay : s.cnt + PERIOD - delay;
        next_s = s;
        next_s.cnt = (s.cnt == PERIOD - 7'h1) ? 7'h0 : s.cnt + 7'h1;
        next_s.out = enable && (pos < (PERIOD >> 1));
        if (apply) begin
            next_s.shift = step_code;
        end
        if (srst || !run) begin
            next_s = '0;
        end
    end

    always_ff @(posedge clock) begin
        s <= next_s;
    end

    assign clk_out = s.out;

    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    phase_hold_a: assert property (run && !apply |=> $stable(s.shift))
        else $error("phase changed without apply");
    phase_load_a: assert property (run && apply |=> s.shift == $past(step_code))
        else $error("phase not loaded while apply high");
    step_delay_a: assert property (
        $rose(clk_out) && $past(run, 2) && $past(enable, 2) && $past(run) &&
        $past(s.shift) == $past(s.shift, 2)
        |-> $past(s.cnt) == PER_W'($past(s.shift) * HALF_STEP_CYCLES))
        else $error("output edge not delayed by step code");
endmodule : pll_output_divider

// ---- test/pll_fabric_user_model.sv ----
`timescale 1ns/1ps
module pll_fabric_user_model (
    input  wire logic       clock,    // System clock
    input  wire logic       clk_zero, // Output zero
    input  wire logic       clk_one,  // Output one
    output logic [3:0]      refs,     // Reference clocks
    output logic            core_fb,  // Core feedback
    output logic            pad_fb    // Pad feedback
);
    logic [7:0] cnt = 8'h00;
    // Periods 16, 32, 16 and 96 clocks, running from time zero
    always @(negedge clock) begin
        cnt <= (cnt == 8'hbf) ? 8'h00 : cnt + 8'h01;
    end
    assign refs    = {(cnt % 8'h60) < 8'h30, cnt[3], cnt[4], cnt[3]};
    assign core_fb = clk_zero;
    assign pad_fb  = clk_one;
endmodule : pll_fabric_user_model

// ---- test/pll_fabric_interface_bench.sv ----
`timescale 1ns/1ps
module pll_fabric_interface_bench;
    import pll_fabric_pkg::*;
    typedef struct packed {logic [1:0] kind; logic [4:0] val;} note_s;
    logic       clock = 1'b0;
    logic       srst = 1'b1;
    logic [3:0] refs;
    logic [1:0] ref_sel = 2'h0;
    logic       rst_n = 1'b1;
    logic       pad_mode = 1'b0;
    logic       core_fb, pad_fb, lock, in_range;
    logic [2:0] step = 3'h0;
    logic [4:0] sel_out = 5'h00;
    logic       strobe = 1'b0;
    logic [4:0] outs;
    note_s      notes[$];
    note_s      n;
    int         err_total = 0, cmp_count = 0, cyc = 0, seed = 22, anchor, s, k, j;

    always #2 clock = ~clock;
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            err_total = err_total + 1;
            tally_and_finish();
        end
    end

    pll_fabric_user_model pll_fabric_user_model_i (.clock(clock), .clk_zero(outs[0]),
        .clk_one(outs[1]), .refs(refs), .core_fb(core_fb), .pad_fb(pad_fb));
    pll_fabric_interface pll_fabric_interface_i (.clock(clock), .srst(srst),
        .reference_clock_inputs(refs), .reference_select(ref_sel), .pll_reset_n(rst_n),
        .feedback_from_pad(pad_mode), .core_feedback_in(core_fb),
        .pad_feedback_in(pad_fb), .phase_step_code(step), .phase_output_select(sel_out),
        .phase_apply_strobe(strobe), .pll_output_zero(outs[0]), .pll_output_one(outs[1]),
        .pll_output_two(outs[2]), .pll_output_three(outs[3]), .pll_output_four(outs[4]),
        .lock_indicator(lock), .output_zero_in_range(in_range));

    task check(input logic [4:0] seen, input logic [4:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task note(input logic [1:0] kind, input logic [4:0] val);
        notes.push_back({kind, val});
    endtask : note

    // Oldest note is judged against the outputs just after each falling edge
    always @(negedge clock) begin
        #1;
        if (notes.size() > 0) begin
            n = notes.pop_front();
            case (n.kind)
                2'h0: check({4'h0, lock}, n.val);
                2'h1: check(outs, n.val);
                2'h2: check({4'h0, in_range}, n.val);
                default: check({4'h0, outs[1]}, n.val);
            endcase
        end
    end

    task restart(input logic [1:0] sel, input logic pad);
        @(negedge clock);
        rst_n = 1'b0;
        ref_sel = sel;
        pad_mode = pad;
        @(negedge clock);
        note(2'h0, 5'h00);
        @(negedge clock);
        note(2'h1, 5'h00);
        @(negedge clock);
        rst_n = 1'b1;
    endtask : restart

    task settle(input logic exp_lock, input logic exp_rng);
        for (int i = 0; i < 400 && lock !== 1'b1; i++) @(negedge clock);
        note(2'h0, {4'h0, exp_lock});
        @(negedge clock);
        note(2'h2, {4'h0, exp_rng});
    endtask : settle

    task tally_and_finish;
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (5) @(negedge clock);
        srst = 1'b0;
        note(2'h1, 5'h00);
        restart(2'h0, 1'b0);
        settle(1'b1, 1'b1);
        restart(2'h1, 1'b0);
        settle(1'b0, 1'b1);
        restart(2'h2, 1'b1);
        settle(1'b1, 1'b1);
        restart(2'h3, 1'b0);
        settle(1'b0, 1'b0);
        restart(2'h0, 1'b0);
        settle(1'b1, 1'b1);
        // Phase reference taken from output one while its shift is zero
        for (k = 0; k < 40 && outs[1] !== 1'b0; k++) @(negedge clock);
        for (k = 0; k < 40 && outs[1] !== 1'b1; k++) @(negedge clock);
        anchor = cyc;
        for (k = 0; k < 4; k++) begin
            s = $random(seed) & 7;
            @(negedge clock);
            step = 3'(s);
            repeat (16) @(negedge clock);
            sel_out = 5'($random(seed)) | 5'h02;
            strobe = 1'b1;
            repeat (64) @(negedge clock);
            sel_out = 5'h00;
            strobe = 1'b0;
            repeat (64) @(negedge clock);
            for (j = 0; j < 32; j++) begin
                @(negedge clock);
                note(2'h3, {4'h0, ((cyc - anchor - s + 1600) % 16) < 8});
            end
        end
        @(negedge clock);
        @(negedge clock);
        tally_and_finish();
    end
endmodule : pll_fabric_interface_bench
